/* File: core/tei_pkg.sv */
// shared constants, types and register map of the tone event interrupt queue
package tei_pkg;

    localparam int unsigned TEI_ADDR_W = 16;
    localparam int unsigned TEI_GROUPS = 16;
    localparam int unsigned TEI_CHANS = 32;
    localparam int unsigned TEI_DEPTH = 32;

    // register indices; byte address is four times the index
    localparam logic [13:0] TEI_IDX_GRP_BASE = 14'h0400;
    localparam logic [13:0] TEI_IDX_GRP_LAST = 14'h040F;
    localparam logic [13:0] TEI_IDX_QUEUE = 14'h0410;
    localparam logic [13:0] TEI_IDX_TEST = 14'h0411;
    localparam logic [13:0] TEI_IDX_STS = 14'h0418;
    localparam logic [13:0] TEI_IDX_CLR = 14'h0419;
    localparam logic [13:0] TEI_IDX_EN = 14'h041A;

    // field positions
    localparam int unsigned TEI_MASK_A_BIT = 3;
    localparam int unsigned TEI_MASK_B_BIT = 4;
    localparam int unsigned TEI_TEST_IRQ_BIT = 0;

    // reset values
    localparam logic [7:0] TEI_GRP_RST = 8'h00;
    localparam logic [7:0] TEI_TEST_RST = 8'h00;
    localparam logic [7:0] TEI_QUEUE_RST = 8'h00;
    localparam logic [2:0] TEI_EVT_RST = 3'h0;

    // AXI response codes
    localparam logic [1:0] TEI_RESP_OKAY = 2'h0;
    localparam logic [1:0] TEI_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_WAIT = 2'b01,
        RD_LOAD = 2'b10,
        RD_RESP = 2'b11
    } tei_rd_state_e;

    // interrupt queue register layout
    typedef struct packed {
        logic pending;
        logic [1:0] zero;
        logic [4:0] chan;
    } tei_queue_s;

    // sticky status / enable / clear layout
    typedef struct packed {
        logic test_entry;
        logic queue_full;
        logic entry_queued;
    } tei_evt_s;

endpackage

/* File: core/tei_queue_mem.sv */
// storage for queued channel numbers with registered read data
`timescale 1ns/1ns
module tei_queue_mem
    import tei_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [4:0] wr_data,
    input wire logic [4:0] rd_addr,
    output logic [4:0] rd_data_ff
);

    logic [4:0] mem [TEI_DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_ff <= 5'h00;
        end else begin
            rd_data_ff <= mem[rd_addr];
        end
    end

endmodule

/* File: core/tei_event_arb.sv */
// per-channel pending latches feeding one channel per cycle to the queue
`timescale 1ns/1ns
module tei_event_arb
    import tei_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [31:0] evt,
    input wire logic take,
    output logic valid,
    output logic [4:0] chan
);

    logic [31:0] pend_ff;
    logic [31:0] nxt_pend;
    logic [31:0] taken_mask;

    // lowest set bit wins
    function automatic logic [4:0] first_set(input logic [31:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = i[4:0];
            end
        end
        return r;
    endfunction

    assign valid = |pend_ff;
    assign chan = first_set(pend_ff);
    assign taken_mask = take ? (32'h00000001 << chan) : 32'h00000000;
    // a new event on the channel being taken keeps it pending
    assign nxt_pend = (pend_ff & ~taken_mask) | evt;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pend_ff <= 32'h00000000;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

endmodule

/* File: core/tei_top.sv */
// tone event interrupt queue with AXI4-Lite register access
//
// Summary of operation
// RQ1: queue bit 7 high while entry pending
// RQ2: queue bits 6 and 5 read zero
// RQ3: queue bits 4:0 give channel number
// RQ4: entry on tone detect and on release
// RQ5: software keeps test bits 7:1 zero
// RQ6: test bit set: mask change queues channel
// RQ7: test bit clear: only detector events queue
// RQ8: per-canceller mask bit high suppresses interrupt
// RQ9: oldest entry read and removed, FIFO order
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module tei_top
    import tei_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [31:0] tone_state,
    input wire logic [TEI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [TEI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    // register file state
    logic [7:0] grp_ff [TEI_GROUPS];
    logic [7:0] test_ff;
    tei_evt_s sts_ff;
    tei_evt_s en_ff;
    logic [31:0] tone_prev_ff;

    // write channel state
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic aw_have_ff;
    logic w_have_ff;
    logic [13:0] aw_idx_ff;
    logic [7:0] w_data_ff;
    logic w_lane0_ff;

    // read channel state
    tei_rd_state_e rd_st_ff;
    tei_rd_state_e nxt_rd_st;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [13:0] ar_idx_ff;
    logic irq_ff;

    // queue state
    logic [4:0] head_ff;
    logic [4:0] tail_ff;
    logic [5:0] count_ff;
    logic [4:0] q_rd_data;

    function automatic logic [13:0] word_index(input logic [TEI_ADDR_W-1:0] a);
        return a[15:2];
    endfunction

    function automatic logic is_grp(input logic [13:0] idx);
        return (idx >= TEI_IDX_GRP_BASE) && (idx <= TEI_IDX_GRP_LAST);
    endfunction

    // ---------------- write path ----------------
    logic aw_take;
    logic w_take;
    logic do_wr;
    logic nxt_aw_have;
    logic nxt_w_have;
    logic wr_grp;
    logic wr_test;
    logic wr_clr;
    logic wr_en_reg;
    logic wr_ok;
    logic [3:0] wr_gsel;

    assign aw_take = s_axi_awvalid & awready_ff;
    assign w_take = s_axi_wvalid & wready_ff;
    assign do_wr = aw_have_ff & w_have_ff & ~bvalid_ff;
    assign nxt_aw_have = (aw_have_ff & ~do_wr) | aw_take;
    assign nxt_w_have = (w_have_ff & ~do_wr) | w_take;
    assign wr_gsel = aw_idx_ff[3:0];
    assign wr_grp = do_wr & w_lane0_ff & is_grp(aw_idx_ff);
    assign wr_test = do_wr & w_lane0_ff & (aw_idx_ff == TEI_IDX_TEST);
    assign wr_clr = do_wr & w_lane0_ff & (aw_idx_ff == TEI_IDX_CLR);
    assign wr_en_reg = do_wr & w_lane0_ff & (aw_idx_ff == TEI_IDX_EN);
    assign wr_ok = is_grp(aw_idx_ff) || (aw_idx_ff == TEI_IDX_TEST)
        || (aw_idx_ff == TEI_IDX_CLR) || (aw_idx_ff == TEI_IDX_EN)
        || (aw_idx_ff == TEI_IDX_QUEUE) || (aw_idx_ff == TEI_IDX_STS);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_idx_ff <= 14'h0000;
            w_data_ff <= 8'h00;
            w_lane0_ff <= 1'b0;
        end else begin
            aw_have_ff <= nxt_aw_have;
            w_have_ff <= nxt_w_have;
            awready_ff <= ~nxt_aw_have;
            wready_ff <= ~nxt_w_have;
            if (aw_take) begin
                aw_idx_ff <= word_index(s_axi_awaddr);
            end
            if (w_take) begin
                w_data_ff <= s_axi_wdata[7:0];
                w_lane0_ff <= s_axi_wstrb[0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= TEI_RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? TEI_RESP_OKAY : TEI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ---------------- control registers ----------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int g = 0; g < TEI_GROUPS; g++) begin
                grp_ff[g] <= TEI_GRP_RST;
            end
            test_ff <= TEI_TEST_RST;
            en_ff <= TEI_EVT_RST;
        end else begin
            if (wr_grp) begin
                grp_ff[wr_gsel] <= w_data_ff;
            end
            if (wr_test) begin
                test_ff <= w_data_ff;
            end
            if (wr_en_reg) begin
                en_ff <= w_data_ff[2:0];
            end
        end
    end

    // ---------------- event sources ----------------
    logic [31:0] tone_chg;
    logic [31:0] chan_mask;
    logic [31:0] tone_evt;
    logic [31:0] test_evt;
    logic test_mode;
    logic [7:0] grp_old;

    assign test_mode = test_ff[TEI_TEST_IRQ_BIT];
    assign grp_old = grp_ff[wr_gsel];

    // RQ8 mask per canceller
    always_comb begin
        chan_mask = 32'h00000000;
        for (int g = 0; g < TEI_GROUPS; g++) begin
            chan_mask[2*g] = grp_ff[g][TEI_MASK_A_BIT];
            chan_mask[2*g+1] = grp_ff[g][TEI_MASK_B_BIT];
        end
    end

    // RQ4 detect and release
    assign tone_chg = tone_state ^ tone_prev_ff;
    // RQ7 detector events only
    assign tone_evt = tone_chg & ~chan_mask;

    // RQ6 mask toggle entries
    always_comb begin
        test_evt = 32'h00000000;
        if (wr_grp && test_mode) begin
            test_evt[{wr_gsel, 1'b0}] = grp_old[TEI_MASK_A_BIT] ^ w_data_ff[TEI_MASK_A_BIT];
            test_evt[{wr_gsel, 1'b1}] = grp_old[TEI_MASK_B_BIT] ^ w_data_ff[TEI_MASK_B_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tone_prev_ff <= 32'h00000000;
        end else begin
            tone_prev_ff <= tone_state;
        end
    end

    // ---------------- queue ----------------
    logic arb_valid;
    logic [4:0] arb_chan;
    logic push;
    logic pop;
    logic q_full;
    logic q_empty;
    logic push_window;

    assign q_full = (count_ff == 6'(TEI_DEPTH));
    assign q_empty = (count_ff == 6'h00);
    // pushes wait while any register read is fetching its data
    assign push_window = (rd_st_ff == RD_IDLE) || (rd_st_ff == RD_RESP);
    assign push = arb_valid & ~q_full & push_window;
    // RQ9 pop on queue read
    assign pop = (rd_st_ff == RD_LOAD) && (ar_idx_ff == TEI_IDX_QUEUE) && ~q_empty;

    tei_event_arb u_arb (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .evt(tone_evt | test_evt),
        .take(push),
        .valid(arb_valid),
        .chan(arb_chan)
    );

    tei_queue_mem u_mem (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr_en(push),
        .wr_addr(tail_ff),
        .wr_data(arb_chan),
        .rd_addr(head_ff),
        .rd_data_ff(q_rd_data)
    );

    // RQ9 arrival order
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            head_ff <= 5'h00;
            tail_ff <= 5'h00;
            count_ff <= 6'h00;
        end else begin
            if (push) begin
                tail_ff <= tail_ff + 5'h01;
            end
            if (pop) begin
                head_ff <= head_ff + 5'h01;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 6'h01;
            end else if (pop && !push) begin
                count_ff <= count_ff - 6'h01;
            end
        end
    end

    // ---------------- interrupt status ----------------
    tei_evt_s evt_now;
    tei_evt_s clr_bits;

    assign evt_now.entry_queued = push;
    assign evt_now.queue_full = push & ~pop & (count_ff == 6'(TEI_DEPTH - 1));
    assign evt_now.test_entry = |test_evt;
    assign clr_bits = wr_clr ? tei_evt_s'(w_data_ff[2:0]) : TEI_EVT_RST;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sts_ff <= TEI_EVT_RST;
            irq_ff <= 1'b0;
        end else begin
            // a set in the clearing cycle wins
            sts_ff <= (sts_ff & ~clr_bits) | evt_now;
            irq_ff <= |(sts_ff & en_ff);
        end
    end

    // ---------------- read path ----------------
    tei_queue_s q_word;
    logic [31:0] rd_word;
    logic rd_ok;
    logic ar_take;

    assign ar_take = s_axi_arvalid & arready_ff;

    // RQ1 pending flag
    assign q_word.pending = ~q_empty;
    // RQ2 zero bits
    assign q_word.zero = 2'h0;
    // RQ3 channel number
    assign q_word.chan = q_empty ? 5'h00 : q_rd_data;

    always_comb begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        if (is_grp(ar_idx_ff)) begin
            rd_word[7:0] = grp_ff[ar_idx_ff[3:0]];
        end else if (ar_idx_ff == TEI_IDX_QUEUE) begin
            rd_word[7:0] = q_word;
        end else if (ar_idx_ff == TEI_IDX_TEST) begin
            rd_word[7:0] = test_ff;
        end else if (ar_idx_ff == TEI_IDX_STS) begin
            rd_word[2:0] = sts_ff;
        end else if (ar_idx_ff == TEI_IDX_EN) begin
            rd_word[2:0] = en_ff;
        end else if (ar_idx_ff == TEI_IDX_CLR) begin
            rd_word = 32'h00000000;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_comb begin
        nxt_rd_st = rd_st_ff;
        case (rd_st_ff)
            RD_IDLE: begin
                if (ar_take) begin
                    nxt_rd_st = RD_WAIT;
                end
            end
            RD_WAIT: begin
                nxt_rd_st = RD_LOAD;
            end
            RD_LOAD: begin
                nxt_rd_st = RD_RESP;
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    nxt_rd_st = RD_IDLE;
                end
            end
            default: begin
                nxt_rd_st = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_st_ff <= RD_IDLE;
            arready_ff <= 1'b0;
            ar_idx_ff <= 14'h0000;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= TEI_RESP_OKAY;
        end else begin
            rd_st_ff <= nxt_rd_st;
            arready_ff <= (nxt_rd_st == RD_IDLE);
            rvalid_ff <= (nxt_rd_st == RD_RESP);
            if (ar_take) begin
                ar_idx_ff <= word_index(s_axi_araddr);
            end
            if (rd_st_ff == RD_LOAD) begin
                rdata_ff <= rd_word;
                rresp_ff <= rd_ok ? TEI_RESP_OKAY : TEI_RESP_SLVERR;
            end
        end
    end

    // ---------------- outputs ----------------
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign irq = irq_ff;

endmodule

/* File: tb/tei_checker.sv */
// concurrent checks on the ports of the tone event interrupt queue
`timescale 1ns/1ns
module tei_checker
    import tei_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [31:0] tone_state,
    input wire logic [TEI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [TEI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    logic [15:0] aw_ff;
    logic [7:0] wd_ff;
    logic rdq_ff;
    logic [2:0] en_ff;
    logic msk_ff;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire rd_q = s_axi_rvalid && rdq_ff;
    wire grp_wr = aw_ff[15:6] == 10'h040;
    // shadow of written address, data, enable and mask use
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aw_ff <= 16'h0000;
            wd_ff <= 8'h00;
            rdq_ff <= 1'b0;
            en_ff <= 3'h0;
            msk_ff <= 1'b0;
        end else begin
            if (aw_hs) aw_ff <= s_axi_awaddr;
            if (w_hs) wd_ff <= s_axi_wdata[7:0];
            if (ar_hs) rdq_ff <= s_axi_araddr == 16'h1040;
            if ($rose(s_axi_bvalid) && aw_ff == 16'h1068) en_ff <= wd_ff[2:0];
            if ($rose(s_axi_bvalid) && grp_wr && wd_ff[4:3] != 2'h0) msk_ff <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_zero_bits: assert property (rd_q |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[6:5] == 2'h0)
        else $error("queue read shows nonzero fixed bits");
    a_empty_chan: assert property (rd_q && !s_axi_rdata[7] |-> s_axi_rdata[4:0] == 5'h00)
        else $error("empty queue read carries a channel");
    a_rd_time: assert property (ar_hs |-> ##1 !s_axi_rvalid ##1 !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("read answer not three cycles after address");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_ar_refuse: assert property (ar_hs |=> !s_axi_arready [*3])
        else $error("second read accepted during a read");
    a_wr_time: assert property (aw_hs && w_hs |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two cycles after handshake");
    a_tone_irq: assert property ($changed(tone_state) && en_ff[0] && !msk_ff |-> ##[1:8] irq)
        else $error("tone change raised no interrupt");
    a_irq_gate: assert property (en_ff == 3'h0 && $past(en_ff) == 3'h0 |-> !irq)
        else $error("interrupt high with nothing enabled");
endmodule

/* File: tb/tei_host_model.sv */
// host register master speaking the lite bus
`timescale 1ns/1ns
module tei_host_model
    import tei_pkg::*;
(
    input wire logic clk_sys,
    output logic [TEI_ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [TEI_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    output logic hang
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, hang} = '0;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        r = 2'bxx;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 64) hang = 1'b1;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        {d, r} = 'x;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 64) hang = 1'b1;
    endtask
endmodule

/* File: tb/tei_top_tb.sv */
// self-checking bench of the tone event interrupt queue
`timescale 1ns/1ns
module tei_top_tb
    import tei_pkg::*;
;
    localparam logic [15:0] A_Q = 16'h1040;
    localparam logic [15:0] A_T = 16'h1044;
    localparam logic [15:0] A_S = 16'h1060;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] tone_state = 32'h0;
    logic [TEI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic irq, hang;
    int error_cnt = 0;
    int cmp_count = 0;
    always #4 clk_sys = ~clk_sys;
    tei_top dut (.*);
    tei_host_model host (.*);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task hung;
        if (hang) begin
            error_cnt++;
            wrap_up;
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
        logic [1:0] r;
        host.wr(a, d, r);
        hung;
        chk({30'h0, r}, {30'h0, er});
    endtask
    task rx(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        hung;
        chk({30'h0, r}, {30'h0, er});
        chk(d, exp);
    endtask
    task tog(input int ch);
        @(posedge clk_sys);
        tone_state[ch] <= ~tone_state[ch];
        repeat (6) @(posedge clk_sys);
    endtask
    task t_reset;
        rx(A_Q, 32'h00, TEI_RESP_OKAY);
        rx(A_T, 32'h00, TEI_RESP_OKAY);
        rx(A_S, 32'h00, TEI_RESP_OKAY);
        wr(A_Q, 8'hFF, TEI_RESP_OKAY);
        rx(A_Q, 32'h00, TEI_RESP_OKAY);
        wr(16'h1070, 8'h01, TEI_RESP_SLVERR);
        rx(16'h1070, 32'h00, TEI_RESP_SLVERR);
        $display("test reset done");
    endtask
    task t_tone;
        wr(16'h1068, 8'h01, TEI_RESP_OKAY);
        tog(5);
        tog(9);
        tog(5);
        chk({31'h0, irq}, 32'h1);
        rx(A_Q, 32'h85, TEI_RESP_OKAY);
        rx(A_Q, 32'h89, TEI_RESP_OKAY);
        rx(A_Q, 32'h85, TEI_RESP_OKAY);
        rx(A_Q, 32'h00, TEI_RESP_OKAY);
        wr(16'h1064, 8'h01, TEI_RESP_OKAY);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        $display("test tone done");
    endtask
    task t_mask;
        wr(16'h100C, 8'h08, TEI_RESP_OKAY);
        tog(6);
        tog(7);
        wr(16'h100C, 8'h00, TEI_RESP_OKAY);
        rx(A_Q, 32'h87, TEI_RESP_OKAY);
        rx(A_Q, 32'h00, TEI_RESP_OKAY);
        $display("test mask done");
    endtask
    task t_full;
        // all channels change at once: lowest first, queue fills
        @(posedge clk_sys);
        tone_state <= ~tone_state;
        repeat (40) @(posedge clk_sys);
        rx(A_S, 32'h03, TEI_RESP_OKAY);
        for (int c = 0; c < 32; c++) begin
            rx(A_Q, 32'h80 | c, TEI_RESP_OKAY);
        end
        rx(A_Q, 32'h00, TEI_RESP_OKAY);
        wr(16'h1064, 8'h07, TEI_RESP_OKAY);
        rx(A_S, 32'h00, TEI_RESP_OKAY);
        $display("test full done");
    endtask
    task t_test;
        wr(A_T, 8'h01, TEI_RESP_OKAY);
        wr(16'h1028, 8'h18, TEI_RESP_OKAY);
        wr(16'h1028, 8'h10, TEI_RESP_OKAY);
        wr(A_T, 8'h00, TEI_RESP_OKAY);
        rx(A_Q, 32'h94, TEI_RESP_OKAY);
        rx(A_Q, 32'h95, TEI_RESP_OKAY);
        rx(A_Q, 32'h94, TEI_RESP_OKAY);
        rx(A_Q, 32'h00, TEI_RESP_OKAY);
        rx(A_S, 32'h05, TEI_RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        wr(16'h1068, 8'h00, TEI_RESP_OKAY);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        $display("test mode done");
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_reset;
        t_tone;
        t_mask;
        t_full;
        t_test;
        wrap_up;
    end
endmodule
bind tei_top tei_checker chk (.*);
